/* rtl/motion_cmd_decoder.v */
`timescale 1ns/1ps
`include "motion_cmd_map.vh"
module motion_cmd_decoder
#(
  parameter ADDR_BITS = 4
)
(
  input  wire                 core_clk,
  input  wire                 rst_n,
  input  wire                 link_clk,
  input  wire                 link_frame,
  input  wire [7:0]           link_byte,
  input  wire [ADDR_BITS-1:0] programmed_address_bits,
  input  wire                 address_pin_level,
  input  wire                 coil_fault,
  input  wire                 motor_moving,
  input  wire                 motor_shutdown,
  input  wire                 move_done,
  input  wire                 status_read_done,
  output reg  [15:0]          actual_position,
  output reg  [15:0]          target_position,
  output reg                  move_start,
  output reg                  bridge_disable,
  output reg                  lost_step_flag,
  output reg                  deadlock,
  output reg                  search_busy,
  output reg  [3:0]           run_current,
  output reg  [3:0]           hold_current,
  output reg  [3:0]           top_speed,
  output reg  [3:0]           min_speed,
  output reg  [3:0]           speed_limit_max,
  output reg  [3:0]           speed_limit_min,
  output reg  [3:0]           ramp_rate_code,
  output reg                  rotation_direction,
  output reg  [10:0]          safe_position,
  output reg  [1:0]           step_resolution,
  output reg                  accel_shape,
  output reg                  pwm_rate_select,
  output reg                  pwm_dither_enable
);
  ////////////////////////////////////////////////////////////////////////////
  wire       byte_valid;
  wire [7:0] byte_data;
  wire       frame_start;
  wire       frame_end;
  wire       fault_s;
  wire       moving_s;
  wire       shutdown_s;
  reg        fault_d;
  reg  [3:0] byte_idx;
  reg        addr_ok;
  reg  [7:0] cmd;
  reg  [7:0] frame_buf [0:8];
  reg  [15:0] search_pos1;
  reg  [15:0] search_pos2;
  reg        halt_seen;
  localparam S_IDLE  = 7'b0000001;
  localparam S_MOVE1 = 7'b0000010;
  localparam S_WAIT1 = 7'b0000100;
  localparam S_MOVE2 = 7'b0001000;
  localparam S_WAIT2 = 7'b0010000;
  localparam S_SAFE  = 7'b0100000;
  localparam S_WAITS = 7'b1000000;
  reg  [6:0] state;
  frame_byte_rx u_rx
  (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .link_clk    (link_clk),
    .link_frame  (link_frame),
    .link_byte   (link_byte),
    .byte_valid  (byte_valid),
    .byte_data   (byte_data),
    .frame_start (frame_start),
    .frame_end   (frame_end)
  );
  pin_sync #(.WIDTH(3)) u_pins
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin      ({coil_fault, motor_moving, motor_shutdown}),
    .synced   ({fault_s, moving_s, shutdown_s})
  );
  ////////////////////////////////////////////////////////////////////////////
  // Frame parsing. Byte 0 is only checked here and no reply is ever driven.
  wire addr_match = (byte_data[7:6] == `ADDR_PREFIX) && !byte_data[0] &&
                    (byte_data[ADDR_BITS+1:2] == programmed_address_bits) &&
                    (byte_data[1] == address_pin_level);
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_idx <= 4'h0;
      addr_ok  <= 1'b0;
      cmd      <= 8'h00;
    end
    else if (frame_start)
    begin
      byte_idx <= 4'h0;
      addr_ok  <= 1'b0;
      cmd      <= 8'h00;
    end
    else if (byte_valid)
    begin
      if (byte_idx == 4'h0)
        addr_ok <= addr_match;
      if (byte_idx == 4'h1)
        cmd <= byte_data;
      if (byte_idx <= `FRAME_LAST_BYTE)
        byte_idx <= byte_idx + 4'h1;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1)
    begin : g_buf
      always @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          frame_buf[g] <= 8'h00;
        else if (byte_valid && byte_idx == g)
          frame_buf[g] <= byte_data;
      end
    end
  endgenerate
  // Short frames execute at frame end; long ones need all nine bytes.
  wire short_ok = addr_ok && byte_idx == 4'h2;
  wire long_ok  = addr_ok && byte_idx == 4'h9 &&
                  frame_buf[2] == `FILLER_BYTE && frame_buf[3] == `FILLER_BYTE;
  wire do_halt    = frame_end && short_ok && cmd == `CMD_EMERGENCY_HALT;
  wire do_clear   = frame_end && short_ok && cmd == `CMD_CLEAR_POSITION;
  wire do_restore = frame_end && short_ok && cmd == `CMD_RESTORE_DEFAULTS;
  wire do_safe    = frame_end && short_ok && cmd == `CMD_MOVE_TO_SAFE;
  wire do_status  = frame_end && short_ok && cmd == `CMD_READ_STATUS_ONE;
  wire do_search  = frame_end && long_ok && cmd == `CMD_REFERENCE_SEARCH;
  wire do_params  = frame_end && long_ok && cmd == `CMD_WRITE_MOTION;
  wire fault_rise = fault_s && !fault_d;
  wire any_halt   = do_halt || fault_rise;
  // The sequencer owns the link while busy or deadlocked, so host commands other than halt and status read are gated.
  wire host_ok    = !search_busy && !deadlock;
  wire safe_en    = safe_position != `SAFE_DISABLED;
  wire [15:0] safe_ext = {{5{safe_position[10]}}, safe_position};
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_d         <= 1'b0;
      halt_seen       <= 1'b0;
      bridge_disable  <= 1'b0;
      lost_step_flag  <= 1'b0;
      deadlock        <= 1'b0;
      search_busy     <= 1'b0;
      state           <= S_IDLE;
      move_start      <= 1'b0;
      actual_position <= 16'h0000;
      target_position <= 16'h0000;
      search_pos1     <= 16'h0000;
      search_pos2     <= 16'h0000;
      speed_limit_max <= `RST_TOP_SPEED;
      speed_limit_min <= `RST_MIN_SPEED;
    end
    else
    begin
      fault_d    <= fault_s;
      move_start <= 1'b0;
      if (move_done)
        actual_position <= target_position;
      if (any_halt)
      begin
        bridge_disable <= 1'b1;
        if (moving_s)
          lost_step_flag <= 1'b1;
        search_busy <= 1'b0;
        state       <= S_IDLE;
        if (deadlock)
          halt_seen <= 1'b1;
      end
      else if (do_status)
      begin
        // The status read releases the bridges and the sticky flag.
        bridge_disable <= 1'b0;
        lost_step_flag <= 1'b0;
        if (halt_seen)
        begin
          deadlock  <= 1'b0;
          halt_seen <= 1'b0;
        end
      end
      else if (shutdown_s && search_busy)
      begin
        search_busy <= 1'b0;
        state       <= S_IDLE;
      end
      else
      begin
        case (state)
          S_IDLE:
          begin
            if (host_ok && do_clear && !moving_s)
            begin
              actual_position <= 16'h0000;
              target_position <= 16'h0000;
            end
            else if (host_ok && do_restore)
            begin
              target_position <= actual_position;
              speed_limit_max <= `RST_TOP_SPEED;
              speed_limit_min <= `RST_MIN_SPEED;
            end
            else if (host_ok && do_safe && safe_en)
            begin
              target_position <= safe_ext;
              move_start      <= 1'b1;
            end
            else if (host_ok && do_params)
            begin
              speed_limit_max <= frame_buf[5][7:4];
              speed_limit_min <= frame_buf[5][3:0];
            end
            else if (host_ok && do_search)
            begin
              speed_limit_max <= frame_buf[4][7:4];
              speed_limit_min <= frame_buf[4][3:0];
              search_pos1     <= {frame_buf[5], frame_buf[6]};
              search_pos2     <= {frame_buf[7], frame_buf[8]};
              search_busy     <= 1'b1;
              // A first target equal to the actual position or to the second target can never complete, which is the deadlock.
              if ({frame_buf[5], frame_buf[6]} == actual_position ||
                  {frame_buf[5], frame_buf[6]} == {frame_buf[7], frame_buf[8]})
                deadlock <= 1'b1;
              state <= S_MOVE1;
            end
          end
          S_MOVE1:
          begin
            target_position <= search_pos1;
            move_start      <= 1'b1;
            state           <= S_WAIT1;
          end
          S_WAIT1:
          begin
            if (move_done && !deadlock)
            begin
              speed_limit_max <= speed_limit_min;
              state           <= S_MOVE2;
            end
          end
          S_MOVE2:
          begin
            target_position <= search_pos2;
            move_start      <= 1'b1;
            state           <= S_WAIT2;
          end
          S_WAIT2:
          begin
            if (move_done && !deadlock)
            begin
              actual_position <= 16'h0000;
              target_position <= 16'h0000;
              if (safe_en)
                state <= S_SAFE;
              else
              begin
                search_busy <= 1'b0;
                state       <= S_IDLE;
              end
            end
          end
          S_SAFE:
          begin
            target_position <= safe_ext;
            move_start      <= 1'b1;
            state           <= S_WAITS;
          end
          S_WAITS:
          begin
            if (move_done)
            begin
              search_busy <= 1'b0;
              state       <= S_IDLE;
            end
          end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Parameter RAM.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_current        <= `RST_RUN_CURRENT;
      hold_current       <= `RST_HOLD_CURRENT;
      top_speed          <= `RST_TOP_SPEED;
      min_speed          <= `RST_MIN_SPEED;
      ramp_rate_code     <= `RST_RAMP_RATE;
      rotation_direction <= `RST_DIRECTION;
      safe_position      <= `RST_SAFE_POSITION;
      step_resolution    <= `RST_STEP_RESOLUTION;
      accel_shape        <= `RST_ACCEL_SHAPE;
      pwm_rate_select    <= `RST_PWM_RATE;
      pwm_dither_enable  <= `RST_PWM_DITHER;
    end
    else if (host_ok && do_restore && state == S_IDLE && !any_halt)
    begin
      run_current        <= `RST_RUN_CURRENT;
      hold_current       <= `RST_HOLD_CURRENT;
      top_speed          <= `RST_TOP_SPEED;
      min_speed          <= `RST_MIN_SPEED;
      ramp_rate_code     <= `RST_RAMP_RATE;
      rotation_direction <= `RST_DIRECTION;
      safe_position      <= `RST_SAFE_POSITION;
      step_resolution    <= `RST_STEP_RESOLUTION;
      accel_shape        <= `RST_ACCEL_SHAPE;
      pwm_rate_select    <= `RST_PWM_RATE;
      pwm_dither_enable  <= `RST_PWM_DITHER;
    end
    else if (host_ok && do_params && state == S_IDLE && !any_halt)
    begin
      run_current        <= frame_buf[4][7:4];
      hold_current       <= frame_buf[4][3:0];
      top_speed          <= frame_buf[5][7:4];
      min_speed          <= frame_buf[5][3:0];
      safe_position      <= {frame_buf[6][7:5], frame_buf[7]};
      rotation_direction <= frame_buf[6][`POS_DIRECTION];
      ramp_rate_code     <= frame_buf[6][3:0];
      pwm_rate_select    <= frame_buf[8][`POS_PWM_RATE];
      accel_shape        <= frame_buf[8][`POS_ACCEL_SHAPE];
      step_resolution    <= frame_buf[8][`POS_STEP_RES_HI:`POS_STEP_RES_LO];
      pwm_dither_enable  <= frame_buf[8][`POS_PWM_DITHER];
    end
  end
endmodule // motion_cmd_decoder

/* rtl/motion_cmd_map.vh */
// Behaviour
// - A coil fault halts the motor and switches both bridges off without a command.
// - A coil fault halt while moving sets the lost step flag.
// - Frame command 0x85 halts the motor exactly like a coil fault halt.
// - Command 0x86 clears actual and target position to zero.
// - Clear position is ignored while the motor velocity is nonzero.
// - Command 0x87 reloads every parameter register with its reset value.
// - Restore defaults keeps actual position and copies it into target position.
// - Reference search: limits max/min, move one, limits min/min, move two, clear, safe move.
// - Reference search runs uninterrupted except by shutdown, emergency halt or coil fault halt.
// - Safe position 0x400 skips the final move of reference search.
// - Broken targets deadlock; only halt then full status read releases it.
// - Reference frame: 0x88, two 0xFF fillers, speed byte, two targets MSB first.
// - Command 0x89 stores currents, speeds, shape, resolution, direction, rate, safe, pwm.
// - Safe position 0x400 disables the later move to safe position commands.
// - Parameter byte 4 holds run/hold current, byte 5 top/min speed, bytes 2-3 filler.
// - Byte 6 holds safe bits 10:8, direction and ramp rate; byte 7 safe low byte.
// - Byte 8 holds pwm rate bit 6, shape bit 4, resolution 3:2, dither bit 0.
// - Move to safe position drives the motor to the signed 11-bit safe position.
// - The address byte is accepted and never sent back by the device.
`ifndef MOTION_CMD_MAP_VH
`define MOTION_CMD_MAP_VH
`define CMD_EMERGENCY_HALT     8'h85
`define CMD_CLEAR_POSITION     8'h86
`define CMD_RESTORE_DEFAULTS   8'h87
`define CMD_REFERENCE_SEARCH   8'h88
`define CMD_WRITE_MOTION       8'h89
`define CMD_READ_STATUS_ONE    8'h81
`define CMD_MOVE_TO_SAFE       8'h84
`define FILLER_BYTE            8'hFF
`define ADDR_PREFIX            2'h3
`define SAFE_DISABLED          11'h400
`define RST_RUN_CURRENT        4'h0
`define RST_HOLD_CURRENT       4'h0
`define RST_TOP_SPEED          4'h0
`define RST_MIN_SPEED          4'h0
`define RST_RAMP_RATE          4'h0
`define RST_DIRECTION          1'h0
`define RST_SAFE_POSITION      11'h400
`define RST_STEP_RESOLUTION    2'h0
`define RST_ACCEL_SHAPE        1'h0
`define RST_PWM_RATE           1'h0
`define RST_PWM_DITHER         1'h0
`define POS_PWM_RATE           6
`define POS_ACCEL_SHAPE        4
`define POS_STEP_RES_HI        3
`define POS_STEP_RES_LO        2
`define POS_PWM_DITHER         0
`define POS_DIRECTION          4
`define FRAME_LAST_BYTE        4'h8
`endif

/* rtl/pin_sync.v */
`timescale 1ns/1ps
module pin_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] synced
);
  reg [WIDTH-1:0] meta;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta   <= {WIDTH{1'b0}};
      synced <= {WIDTH{1'b0}};
    end
    else
    begin
      meta   <= pin;
      synced <= meta;
    end
  end
endmodule // pin_sync

/* rtl/frame_byte_rx.v */
`timescale 1ns/1ps
// Bytes arrive as a strobe with data on the link clock; the strobe is
// sampled and its edge turned into a one-cycle pulse on core_clk.
module frame_byte_rx
(
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       link_clk,
  input  wire       link_frame,
  input  wire [7:0] link_byte,
  output reg        byte_valid,
  output reg  [7:0] byte_data,
  output reg        frame_start,
  output reg        frame_end
);
  wire       clk_s;
  wire       frame_s;
  wire [7:0] data_s;
  reg        clk_d;
  reg        frame_d;
  pin_sync #(.WIDTH(10)) u_sync
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin      ({link_clk, link_frame, link_byte}),
    .synced   ({clk_s, frame_s, data_s})
  );
  // Data is taken on the rising link edge; the host holds it stable around it.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_d       <= 1'b0;
      frame_d     <= 1'b0;
      byte_valid  <= 1'b0;
      byte_data   <= 8'h00;
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
    end
    else
    begin
      clk_d       <= clk_s;
      frame_d     <= frame_s;
      byte_valid  <= frame_s && clk_s && !clk_d;
      frame_start <= frame_s && !frame_d;
      frame_end   <= !frame_s && frame_d;
      if (frame_s && clk_s && !clk_d)
        byte_data <= data_s;
    end
  end
endmodule // frame_byte_rx

/* bench/motion_cmd_decoder_sva.sv */
`timescale 1ns/1ps
`include "motion_cmd_map.vh"
module motion_cmd_decoder_sva
(
  input wire        core_clk,
  input wire        rst_n,
  input wire        coil_fault,
  input wire        motor_moving,
  input wire [15:0] actual_position,
  input wire [15:0] target_position,
  input wire        move_start,
  input wire        bridge_disable,
  input wire        lost_step_flag,
  input wire        deadlock,
  input wire        search_busy,
  input wire [3:0]  run_current,
  input wire [10:0] safe_position
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // The clear step of a search is the cycle where the position drops to zero.
  // The busy flag falls on that same edge when the safe move is skipped.
  sequence s_clear_step;
    $past(search_busy) && $changed(actual_position) && actual_position == 16'h0000;
  endsequence
  sequence s_safe_move;
    move_start && target_position == {{5{safe_position[10]}}, safe_position};
  endsequence
  property p_fault_halt;
    $rose(coil_fault) |-> ##[1:8] bridge_disable;
  endproperty
  a_fault_halt: assert property (p_fault_halt)
    else $error("bridges still on after coil fault");
  property p_fault_lost;
    $rose(coil_fault) && motor_moving |-> ##[1:8] lost_step_flag;
  endproperty
  a_fault_lost: assert property (p_fault_lost)
    else $error("lost step flag missing after fault while moving");
  property p_clear_zero;
    $changed(actual_position) && !search_busy && !$past(search_busy) |->
      actual_position == 16'h0000
      && target_position == 16'h0000;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("position changed to a value other than zero");
  property p_no_clear_moving;
    $past(motor_moving, 6) && motor_moving |-> $stable(actual_position);
  endproperty
  a_no_clear_moving: assert property (p_no_clear_moving)
    else $error("position changed while moving");
  property p_search_hold;
    search_busy && $past(search_busy) |-> $stable(run_current);
  endproperty
  a_search_hold: assert property (p_search_hold)
    else $error("parameters changed during search");
  property p_deadlock_hold;
    $fell(deadlock) |-> $past(bridge_disable);
  endproperty
  a_deadlock_hold: assert property (p_deadlock_hold)
    else $error("deadlock left without a halt");
  property p_safe_skip;
    s_clear_step and safe_position == `SAFE_DISABLED |-> (!move_start) [*6];
  endproperty
  a_safe_skip: assert property (p_safe_skip)
    else $error("final move issued with safe position disabled");
  property p_safe_move;
    s_clear_step and safe_position != `SAFE_DISABLED |-> ##[0:8] s_safe_move;
  endproperty
  a_safe_move: assert property (p_safe_move)
    else $error("final move missing or wrong target");
endmodule // motion_cmd_decoder_sva

bind motion_cmd_decoder motion_cmd_decoder_sva chk
(
  .core_clk, .rst_n, .coil_fault, .motor_moving, .actual_position, .target_position,
  .move_start, .bridge_disable, .lost_step_flag, .deadlock, .search_busy, .run_current,
  .safe_position
);

/* bench/host_link_model.sv */
`timescale 1ns/1ps
module host_link_model
(
  output logic       link_clk,
  output logic       link_frame,
  output logic [7:0] link_byte
);
  initial
  begin
    link_clk = 1'b0;
    link_frame = 1'b0;
    link_byte = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // The strobe clock stands still between frames, and the data lines show the
  // inverse of the last byte so that nothing stale can pass for a value.
  task automatic send_frame(input logic [7:0] q[$]);
    int i;
    #100;
    link_frame = 1'b1;
    for (i = 0; i < q.size(); i++)
    begin
      link_byte = q[i];
      #50 link_clk = 1'b1;
      #100 link_clk = 1'b0;
      #50;
    end
    link_frame = 1'b0;
    link_byte = ~link_byte;
  endtask
endmodule // host_link_model

/* bench/motion_cmd_decoder_tb.sv */
`timescale 1ns/1ps
`include "motion_cmd_map.vh"
module motion_cmd_decoder_tb;
  localparam logic [7:0] ADR = 8'hEA;
  logic        core_clk, rst_n, coil_fault, motor_moving, move_done, motor_shutdown;
  wire         link_clk, link_frame, move_start, bridge_disable, lost_step_flag;
  wire         deadlock, search_busy, rotation_direction, accel_shape;
  wire         pwm_rate_select, pwm_dither_enable;
  wire [7:0]   link_byte;
  wire [15:0]  actual_position, target_position;
  wire [3:0]   run_current, hold_current, top_speed, min_speed;
  wire [3:0]   speed_limit_max, speed_limit_min, ramp_rate_code;
  wire [10:0]  safe_position;
  wire [1:0]   step_resolution;
  int          n_mismatch, compares, cycles;
  host_link_model host (.link_clk, .link_frame, .link_byte);
  motion_cmd_decoder #(.ADDR_BITS(4)) uut
  (
    .core_clk, .rst_n, .link_clk, .link_frame, .link_byte,
    .programmed_address_bits(4'hA), .address_pin_level(1'b1), .coil_fault, .motor_moving,
    .motor_shutdown, .move_done, .status_read_done(1'b0), .actual_position,
    .target_position, .move_start, .bridge_disable, .lost_step_flag, .deadlock, .search_busy,
    .run_current, .hold_current, .top_speed, .min_speed, .speed_limit_max, .speed_limit_min,
    .ramp_rate_code, .rotation_direction, .safe_position, .step_resolution, .accel_shape,
    .pwm_rate_select, .pwm_dither_enable
  );
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic frame(input logic [7:0] q[$]);
    host.send_frame(q);
    repeat (10) @(negedge core_clk);
  endtask
  task automatic wr_params(input logic [7:0] b4, b5, b6, b7, b8, adr);
    frame({adr, `CMD_WRITE_MOTION, `FILLER_BYTE, `FILLER_BYTE, b4, b5, b6, b7, b8});
  endtask
  // The move is awaited with a bound so a silent design cannot hang the run.
  task automatic wait_move;
    int i;
    for (i = 0; i < 400 && move_start !== 1'b1; i++) @(negedge core_clk);
    chk("move_start", move_start, 1'b1);
    @(negedge core_clk);
  endtask
  task automatic done_pulse;
    move_done = 1'b1;
    @(negedge core_clk);
    move_done = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_params;
    wr_params(8'h11, 8'h11, 8'h11, 8'h11, 8'hFB, 8'hE6);
    chk("run_current", run_current, 4'h0);
    wr_params(8'h11, 8'h11, 8'h11, 8'h11, 8'hFB, 8'hEB);
    chk("hold_current", hold_current, 4'h0);
    wr_params(8'hD5, 8'hA3, 8'h82, 8'h00, 8'hA6, ADR);
    chk("run_current", run_current, 4'hD);
    chk("hold_current", hold_current, 4'h5);
    chk("top_speed", top_speed, 4'hA);
    chk("min_speed", min_speed, 4'h3);
    chk("safe_position", safe_position, 11'h400);
    chk("ramp_rate_code", ramp_rate_code, 4'h2);
    chk("step_resolution", step_resolution, 2'h1);
    chk("pwm_bits", {pwm_rate_select, accel_shape, pwm_dither_enable}, 3'h0);
  endtask
  task automatic t_params_two;
    wr_params(8'h5D, 8'h3A, 8'h19, 8'h05, 8'hFB, ADR);
    chk("safe_position", safe_position, 11'h005);
    chk("direction_rate", {rotation_direction, ramp_rate_code}, 5'h19);
    chk("step_resolution", step_resolution, 2'h2);
    chk("pwm_bits", {pwm_rate_select, accel_shape, pwm_dither_enable}, 3'h7);
  endtask
  task automatic t_search(input logic [15:0] p1, p2, input logic [3:0] run, input bit safe);
    host.send_frame({ADR, `CMD_REFERENCE_SEARCH, `FILLER_BYTE, `FILLER_BYTE, 8'hA3,
                     p1[15:8], p1[7:0], p2[15:8], p2[7:0]});
    wait_move;
    chk("limits_one", {speed_limit_max, speed_limit_min, target_position}, {8'hA3, p1});
    done_pulse;
    wait_move;
    chk("limits_two", {speed_limit_max, speed_limit_min, target_position}, {8'h33, p2});
    wr_params(8'hEE, 8'hEE, 8'hEE, 8'hEE, 8'hFF, ADR);
    chk("run_current", run_current, run);
    done_pulse;
    if (safe)
    begin
      wait_move;
      chk("safe_target", target_position, 16'h0005);
      done_pulse;
    end
    repeat (10) @(negedge core_clk);
    chk("search_busy", search_busy, 1'b0);
    chk("actual_position", actual_position, safe ? 16'h0005 : 16'h0000);
  endtask
  task automatic t_restore_clear;
    frame({ADR, `CMD_RESTORE_DEFAULTS});
    chk("params", {run_current, hold_current, top_speed, min_speed}, 16'h0000);
    chk("safe_position", safe_position, 11'h400);
    chk("positions", {actual_position, target_position}, 32'h00050005);
    chk("actual_position", actual_position, 16'h0005);
    frame({ADR, `CMD_MOVE_TO_SAFE});
    chk("safe_ignored", target_position, 16'h0005);
    motor_moving = 1'b1;
    frame({ADR, `CMD_CLEAR_POSITION});
    chk("actual_position", actual_position, 16'h0005);
    motor_moving = 1'b0;
    frame({ADR, `CMD_CLEAR_POSITION});
    chk("positions", {actual_position, target_position}, 16'h0000);
  endtask
  task automatic t_halt;
    frame({ADR, `CMD_EMERGENCY_HALT});
    chk("halt_bits", {bridge_disable, lost_step_flag}, 2'h2);
    frame({ADR, `CMD_READ_STATUS_ONE});
    motor_moving = 1'b1;
    repeat (8) @(negedge core_clk);
    coil_fault = 1'b1;
    repeat (10) @(negedge core_clk);
    chk("fault_bits", {bridge_disable, lost_step_flag}, 2'h3);
    coil_fault = 1'b0;
    motor_moving = 1'b0;
    frame({ADR, `CMD_READ_STATUS_ONE});
    chk("status_clear", {bridge_disable, lost_step_flag}, 2'h0);
  endtask
  task automatic t_deadlock;
    frame({ADR, `CMD_REFERENCE_SEARCH, `FILLER_BYTE, `FILLER_BYTE, 8'hA3,
           8'h00, 8'h30, 8'h00, 8'h30});
    chk("deadlock", deadlock, 1'b1);
    frame({ADR, `CMD_READ_STATUS_ONE});
    chk("deadlock", deadlock, 1'b1);
    frame({ADR, `CMD_EMERGENCY_HALT});
    chk("deadlock", {deadlock, bridge_disable}, 2'h3);
    frame({ADR, `CMD_READ_STATUS_ONE});
    chk("deadlock", deadlock, 1'b0);
  endtask
  task automatic t_abort;
    frame({ADR, `CMD_REFERENCE_SEARCH, `FILLER_BYTE, `FILLER_BYTE, 8'hA3,
           8'h00, 8'h40, 8'h00, 8'h20});
    chk("search_busy", search_busy, 1'b1);
    motor_shutdown = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("search_busy", search_busy, 1'b0);
    chk("target_position", target_position, 16'h0040);
    motor_shutdown = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial
  begin
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    rst_n = 1'b0;
    coil_fault = 1'b0;
    motor_moving = 1'b0;
    move_done = 1'b0;
    motor_shutdown = 1'b0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("reset_outputs", {bridge_disable, deadlock, search_busy, run_current}, 7'h00);
    chk("reset_safe", safe_position, 11'h400);
    t_params;
    t_search(16'h0200, 16'h0080, 4'hD, 1'b0);
    t_params_two;
    t_search(16'h0100, 16'h0050, 4'h5, 1'b1);
    t_restore_clear;
    t_halt;
    t_abort;
    t_deadlock;
    print_verdict;
  end
endmodule // motion_cmd_decoder_tb
